/* File: hw/imem_sync_pkg.sv */
// constants for the instruction-memory synchronisation unit
package imem_sync_pkg;
  localparam int          XLEN          = 64;
  localparam logic [1:0]  OP_MEM_CLASS  = 2'h2;
  localparam logic [5:0]  OPCODE_SYNC   = 6'h3b;
  localparam int          OP_HI         = 31;
  localparam int          OP_LO         = 30;
  localparam int          OPX_HI        = 24;
  localparam int          OPX_LO        = 19;
  localparam int          RS1_HI        = 18;
  localparam int          RS1_LO        = 14;
  localparam int          IMM_SEL_BIT   = 13;
  localparam int          IMM_HI        = 12;
  localparam int          IMM_LO        = 0;
  localparam int          RS2_HI        = 4;
  localparam int          RS2_LO        = 0;
  localparam int          ALIGN_BITS    = 3;
  localparam int          REG_IDX_W     = 5;
  localparam int          IMM_W         = 13;
  localparam int          LOG_DEPTH     = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ_OPS,
    ST_DRAIN,
    ST_ISSUE,
    ST_WAIT_ACK,
    ST_FLUSH_PIPE
  } sync_state_t;
endpackage : imem_sync_pkg

/* File: hw/instruction_memory_sync_unit.sv */
// instruction-memory synchronisation unit: decode, address, drain, order, flush
module instruction_memory_sync_unit
  import imem_sync_pkg::*;
#(
  parameter int  ADDR_W       = XLEN,
  parameter bit  HW_COHERENT  = 1'b0
) (
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  ce_i,
  // issue side
  input  wire logic                  insn_valid_i,
  input  wire logic [31:0]           insn_i,
  input  wire logic [ADDR_W-1:0]     insn_pc_i,
  output logic                       insn_ready_o,
  output logic                       is_sync_o,
  // register file read
  output logic      [REG_IDX_W-1:0]  rf_raddr1_o,
  output logic      [REG_IDX_W-1:0]  rf_raddr2_o,
  input  wire logic [ADDR_W-1:0]     rf_rdata1_i,
  input  wire logic [ADDR_W-1:0]     rf_rdata2_i,
  // store drain and memory ordering
  input  wire logic                  stores_pending_i,
  output logic                       store_order_slot_o,
  // cache hierarchy
  output logic                       cache_sync_req_o,
  output logic      [ADDR_W-1:0]     cache_sync_addr_o,
  output logic                       cache_sync_xlate_o,
  input  wire logic                  cache_sync_ack_i,
  input  wire logic                  cache_sync_fault_i,
  // fetch path
  output logic                       pipe_flush_o,
  output logic                       prefetch_inval_o,
  output logic      [ADDR_W-1:0]     refetch_pc_o,
  output logic                       data_fault_o,
  output logic                       busy_o,
  output logic      [ADDR_W-1:0]     last_sync_addr_o
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic dec_sync;
  assign dec_sync = (insn_i[OP_HI:OP_LO] == OP_MEM_CLASS)
                 && (insn_i[OPX_HI:OPX_LO] == OPCODE_SYNC);

  sync_state_t                 state_q;
  logic                        imm_sel_q;
  logic [IMM_W-1:0]            signed_imm_field_q;
  logic [REG_IDX_W-1:0]        first_source_reg_q;
  logic [REG_IDX_W-1:0]        second_source_reg_q;
  logic [ADDR_W-1:0]           pc_q;
  logic [ADDR_W-1:0]           addr_q;
  logic                        fault_q;
  logic [LOG_DEPTH-1:0]        log_ptr_q;

  assign insn_ready_o = (state_q == ST_IDLE);
  assign is_sync_o    = insn_valid_i && dec_sync;
  assign busy_o       = (state_q != ST_IDLE);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      imm_sel_q           <= 1'b0;
      signed_imm_field_q  <= '0;
      first_source_reg_q  <= '0;
      second_source_reg_q <= '0;
      pc_q                <= '0;
    end else if (ce_i && insn_ready_o && insn_valid_i && dec_sync) begin
      imm_sel_q           <= insn_i[IMM_SEL_BIT];
      signed_imm_field_q  <= insn_i[IMM_HI:IMM_LO];
      first_source_reg_q  <= insn_i[RS1_HI:RS1_LO];
      second_source_reg_q <= insn_i[RS2_HI:RS2_LO];
      pc_q                <= insn_pc_i;
    end
  end

  assign rf_raddr1_o = first_source_reg_q;
  assign rf_raddr2_o = second_source_reg_q;

  // ----------------------------------------------------------------
  // effective address
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] operand_b;
  logic [ADDR_W-1:0] raw_sum;
  logic [ADDR_W-1:0] eff_addr;
  assign operand_b = imm_sel_q ? {{(ADDR_W-IMM_W){signed_imm_field_q[IMM_W-1]}}, signed_imm_field_q}
                               : rf_rdata2_i;
  assign raw_sum   = rf_rdata1_i + operand_b;
  // low bits dropped only after the add, so their carry still counts
  assign eff_addr  = {raw_sum[ADDR_W-1:ALIGN_BITS], {ALIGN_BITS{1'b0}}};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      addr_q <= '0;
    end else if (ce_i && state_q == ST_READ_OPS) begin
      addr_q <= eff_addr;
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
    end else if (ce_i) begin
      case (state_q)
        ST_IDLE: begin
          if (insn_valid_i && dec_sync) begin
            state_q <= ST_READ_OPS;
          end
        end
        ST_READ_OPS: begin
          state_q <= ST_DRAIN;
        end
        ST_DRAIN: begin
          // waiting on the whole store queue is coarse but always safe
          if (!stores_pending_i) begin
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          state_q <= ST_WAIT_ACK;
        end
        ST_WAIT_ACK: begin
          if (cache_sync_ack_i) begin
            state_q <= ST_FLUSH_PIPE;
          end
        end
        ST_FLUSH_PIPE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ordering slot: one store-class entry so barriers see a store
  assign store_order_slot_o = (state_q == ST_ISSUE);

  // ----------------------------------------------------------------
  // cache request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cache_sync_req_o   <= 1'b0;
      cache_sync_addr_o  <= '0;
      cache_sync_xlate_o <= 1'b0;
    end else if (ce_i) begin
      if (state_q == ST_ISSUE) begin
        cache_sync_req_o   <= 1'b1;
        cache_sync_addr_o  <= HW_COHERENT ? '0 : addr_q;
        cache_sync_xlate_o <= !HW_COHERENT;
      end else if (cache_sync_ack_i) begin
        cache_sync_req_o   <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fault_q <= 1'b0;
    end else if (ce_i) begin
      if (state_q == ST_ISSUE) begin
        fault_q <= 1'b0;
      end else if (state_q == ST_WAIT_ACK && cache_sync_ack_i) begin
        fault_q <= cache_sync_fault_i && !HW_COHERENT;
      end
    end
  end

  // ----------------------------------------------------------------
  // fetch-side effects
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pipe_flush_o     <= 1'b0;
      prefetch_inval_o <= 1'b0;
      refetch_pc_o     <= '0;
      data_fault_o     <= 1'b0;
    end else if (ce_i) begin
      pipe_flush_o     <= (state_q == ST_FLUSH_PIPE);
      prefetch_inval_o <= (state_q == ST_FLUSH_PIPE);
      data_fault_o     <= (state_q == ST_FLUSH_PIPE) && fault_q;
      if (state_q == ST_FLUSH_PIPE) begin
        refetch_pc_o <= pc_q + ADDR_W'(4);
      end
    end
  end

  // ----------------------------------------------------------------
  // address log
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      log_ptr_q <= '0;
    end else if (ce_i && state_q == ST_FLUSH_PIPE) begin
      log_ptr_q <= log_ptr_q + 1'b1;
    end
  end

  sync_addr_log #(
    .DEPTH_LOG (LOG_DEPTH),
    .WIDTH     (ADDR_W)
  ) u_log (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (state_q == ST_FLUSH_PIPE),
    .waddr_i (log_ptr_q),
    .wdata_i (addr_q),
    .raddr_i (log_ptr_q - 1'b1),
    .rdata_o (last_sync_addr_o)
  );
endmodule : instruction_memory_sync_unit

/* File: hw/sync_addr_log.sv */
// small memory holding the aligned addresses of issued synchronisations
module sync_addr_log
  import imem_sync_pkg::*;
#(
  parameter int DEPTH_LOG = LOG_DEPTH,
  parameter int WIDTH     = XLEN
) (
  input  wire logic                 clk_i,
  input  wire logic                 ce_i,
  input  wire logic                 we_i,
  input  wire logic [DEPTH_LOG-1:0] waddr_i,
  input  wire logic [WIDTH-1:0]     wdata_i,
  input  wire logic [DEPTH_LOG-1:0] raddr_i,
  output logic      [WIDTH-1:0]     rdata_o
);
  logic [WIDTH-1:0] mem_q [2**DEPTH_LOG];

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule : sync_addr_log

/* File: test/cache_sync_model.sv */
// cache side model answering sync requests with ack and fault
module cache_sync_model (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       req_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       fault_en_i,
  output logic            ack_o,
  output logic            fault_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // one ack per request; fault toggles outside ack so a stray sample shows
  always_ff @(posedge clk_i) begin
    ack_o   <= !reset_i && req_i && !ack_o && wait_q == delay_i;
    wait_q  <= (req_i && !ack_o && !reset_i) ? wait_q + 4'h1 : 4'h0;
    fault_o <= !reset_i && ((req_i && !ack_o && wait_q == delay_i) ? fault_en_i : !fault_o);
  end
endmodule : cache_sync_model

/* File: test/sync_unit_checker.sv */
// port assertions for the sync unit
module sync_unit_checker
  import imem_sync_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        ce_i,
  input wire logic        insn_valid_i,
  input wire logic [31:0] insn_i,
  input wire logic        is_sync_o,
  input wire logic        stores_pending_i,
  input wire logic        store_order_slot_o,
  input wire logic        cache_sync_req_o,
  input wire logic [63:0] cache_sync_addr_o,
  input wire logic        cache_sync_xlate_o,
  input wire logic        cache_sync_ack_i,
  input wire logic        cache_sync_fault_i,
  input wire logic        pipe_flush_o,
  input wire logic        prefetch_inval_o,
  input wire logic        data_fault_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ------------------------------
  // handshake steps
  // ------------------------------
  sequence s_ack;
    cache_sync_req_o && cache_sync_ack_i && ce_i;
  endsequence
  sequence s_flush;
    pipe_flush_o && prefetch_inval_o;
  endsequence
  AST_DECODE: assert property (is_sync_o == (insn_valid_i && insn_i[OP_HI:OP_LO] == OP_MEM_CLASS
    && insn_i[OPX_HI:OPX_LO] == OPCODE_SYNC)) else $error("decode mismatch");
  AST_ALIGN: assert property (cache_sync_req_o |-> cache_sync_addr_o[2:0] == 3'h0)
    else $error("unaligned address");
  AST_DRAIN: assert property (store_order_slot_o |-> !$past(stores_pending_i))
    else $error("issued with stores pending");
  AST_STORE_SLOT: assert property (store_order_slot_o && ce_i |=> cache_sync_req_o)
    else $error("no request after ordering slot");
  AST_REQ_HOLD: assert property (cache_sync_req_o && !cache_sync_ack_i && ce_i |=>
    cache_sync_req_o && $stable(cache_sync_addr_o)) else $error("request dropped early");
  AST_FLUSH: assert property (s_ack |-> ##2 s_flush)
    else $error("no flush after ack");
  AST_FAULT: assert property (s_ack ##0 cache_sync_fault_i |-> ##2 data_fault_o)
    else $error("fault not reported");
  AST_XLATE: assert property (cache_sync_req_o |-> cache_sync_xlate_o)
    else $error("translate missing");
endmodule : sync_unit_checker

bind instruction_memory_sync_unit sync_unit_checker chk (.*);

/* File: test/tb.sv */
// self-checking bench for the sync unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import imem_sync_pkg::*;
  logic        clk_i, reset_i, ce_i, insn_valid_i, stores_pending_i, cache_sync_ack_i, cache_sync_fault_i;
  logic        insn_ready_o, is_sync_o, store_order_slot_o, cache_sync_req_o, cache_sync_xlate_o;
  logic        pipe_flush_o, prefetch_inval_o, data_fault_o, busy_o, flt_en;
  logic [31:0] insn_i;
  logic [63:0] insn_pc_i, rf_rdata1_i, rf_rdata2_i, cache_sync_addr_o, refetch_pc_o, last_sync_addr_o;
  logic [4:0]  rf_raddr1_o, rf_raddr2_o;
  logic [3:0]  dly;
  int          n_fail = 0, samples_checked = 0, cyc = 0;
  instruction_memory_sync_unit dut (.*);
  cache_sync_model partner (.clk_i(clk_i), .reset_i(reset_i), .req_i(cache_sync_req_o), .delay_i(dly),
    .fault_en_i(flt_en), .ack_o(cache_sync_ack_i), .fault_o(cache_sync_fault_i));
  // register file: odd low bits so alignment shows
  function automatic logic [63:0] rfv(input logic [4:0] idx);
    return 64'h0000_0012_3450_0003 + {51'h0, idx, 8'h0};
  endfunction : rfv
  assign rf_rdata1_i = rfv(rf_raddr1_o);
  assign rf_rdata2_i = rfv(rf_raddr2_o);
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      test_done();
    end
  end
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic run_sync(input logic [31:0] w, input logic [63:0] pc, input logic [63:0] ea, input int pend,
                          input logic f);
    int n;
    int slot_seen = 0;
    @(negedge clk_i);
    insn_i = w;
    insn_pc_i = pc;
    insn_valid_i = 1'b1;
    stores_pending_i = pend > 0;
    flt_en = f;
    #1 check("is sync", is_sync_o, 1'b1);
    @(negedge clk_i);
    insn_valid_i = 1'b0;
    check("busy", busy_o, 1'b1);
    for (n = 0; n < 40 && !cache_sync_req_o; n++) begin
      if (n == pend) stores_pending_i = 1'b0;
      slot_seen += store_order_slot_o;
      @(negedge clk_i);
    end
    check("drain", n > pend, 1'b1);
    check("slot", slot_seen, 1);
    check("addr", cache_sync_addr_o, ea);
    check("xlate", cache_sync_xlate_o, 1'b1);
    for (n = 0; n < 40 && !pipe_flush_o; n++) @(negedge clk_i);
    check("flush", pipe_flush_o, 1'b1);
    check("inval", prefetch_inval_o, 1'b1);
    check("refetch", refetch_pc_o, pc + 64'h4);
    check("fault", data_fault_o, f);
    @(negedge clk_i);
    check("pulse", pipe_flush_o, 1'b0);
    check("log", last_sync_addr_o, ea);
    check("ready", insn_ready_o, 1'b1);
  endtask : run_sync
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_not_sync();
    logic [31:0] w [2] = '{32'h81d0_0000, 32'hc1d8_0000};
    foreach (w[k]) begin
      @(negedge clk_i);
      insn_i = w[k];
      insn_valid_i = 1'b1;
      #1 check("decode", is_sync_o, 1'b0);
      @(negedge clk_i);
      insn_valid_i = 1'b0;
      check("idle", busy_o, 1'b0);
    end
    $display("t_not_sync done");
  endtask : t_not_sync
  task automatic t_ce_hold();
    @(negedge clk_i);
    ce_i = 1'b0;
    insn_i = {2'h2, 5'h0, 6'h3b, 5'h1, 1'b0, 8'h0, 5'h2};
    insn_valid_i = 1'b1;
    repeat (2) begin
      @(negedge clk_i);
      check("frozen", busy_o, 1'b0);
    end
    insn_valid_i = 1'b0;
    ce_i = 1'b1;
    @(negedge clk_i);
    check("after freeze", busy_o, 1'b0);
    $display("t_ce_hold done");
  endtask : t_ce_hold
  task automatic t_reg_drain();
    dly = 4'h0;
    run_sync({2'h2, 5'h0, 6'h3b, 5'h3, 1'b0, 8'h0, 5'h5}, 64'h0000_0000_0000_1000,
             (rfv(5'h3) + rfv(5'h5)) & ~64'h7, 4, 1'b0);
    $display("t_reg_drain done");
  endtask : t_reg_drain
  task automatic t_imm_fault();
    dly = 4'h6;
    run_sync({2'h2, 5'h0, 6'h3b, 5'h7, 1'b1, 13'h1fec}, 64'h0000_0000_0000_2004,
             (rfv(5'h7) - 64'h14) & ~64'h7, 0, 1'b1);
    run_sync({2'h2, 5'h1f, 6'h3b, 5'h9, 1'b1, 13'h0fff}, 64'h0000_0000_0000_3008,
             (rfv(5'h9) + 64'hfff) & ~64'h7, 1, 1'b0);
    $display("t_imm_fault done");
  endtask : t_imm_fault
  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    insn_valid_i = 1'b0;
    insn_i = 32'h0;
    insn_pc_i = 64'h0;
    stores_pending_i = 1'b0;
    flt_en = 1'b0;
    dly = 4'h0;
    repeat (5) @(negedge clk_i);
    reset_i = 1'b0;
    check("reset ready", insn_ready_o, 1'b1);
    check("reset req", cache_sync_req_o, 1'b0);
    t_not_sync();
    t_ce_hold();
    t_reg_drain();
    t_imm_fault();
    test_done();
  end
endmodule : tb
